/* File: dv/pscr_power_state_config_regs_tb_top.sv */
// Self-checking testbench for the power state register bank
`timescale 1ns/1ps
module pscr_power_state_config_regs_tb_top;
  import pscr_pkg::*;
  localparam logic [63:0] CAP_EXP = 64'h0000_0C00_1000_0000;
  logic                clock = 1'b0;
  logic                rst_n = 1'b0;
  pscr_addr_t          regAddr = 8'h00;
  pscr_data_t          regWdata = 64'h0;
  logic                regWrite = 1'b0;
  logic                regRead = 1'b0;
  pscr_data_t          regRdata;
  logic                ioRead = 1'b0;
  logic [15:0]         ioPort = 16'h0000;
  logic                ioConsumed, idleRequest, eventValid = 1'b0;
  logic [3:0]          eventTarget = 4'h0;
  logic [3:0]          coreDeepIdle = 4'h0;
  logic [3:0]          coreWake;
  logic [2:0]          pkgDeepestState;
  logic                pkgIdleAllowed;
  int                  n_mismatch = 0;
  int                  comparisons = 0;
  // Reserved codes 101b and 110b are never written
  logic [2:0]          codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  logic [2:0]          states [6] = '{3'h0, 3'h0, 3'h3, 3'h3, 3'h4, 3'h7};
  pscr_power_state_config_regs #(.FACTORY_LIMIT(3'h4), .RATIO_PROG(1'b1),
    .LIMIT_PROG(1'b0), .EFF_RATIO(8'h0C), .CORES(4))
    u_pscr_power_state_config_regs (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .ioRead(ioRead), .ioPort(ioPort), .ioConsumed(ioConsumed),
    .idleRequest(idleRequest), .eventValid(eventValid),
    .eventTarget(eventTarget), .coreDeepIdle(coreDeepIdle),
    .coreWake(coreWake), .pkgDeepestState(pkgDeepestState),
    .pkgIdleAllowed(pkgIdleAllowed));
  always #50 clock = ~clock;
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input pscr_addr_t a, input pscr_data_t d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(input pscr_addr_t a, input pscr_data_t exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 cmp(regRdata, exp);
  endtask
  task automatic drive(input logic [15:0] port, input logic [3:0] tgt);
    @(posedge clock);
    ioRead <= 1'b1;
    ioPort <= port;
    eventValid <= 1'b1;
    eventTarget <= tgt;
    #1;
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    test_done();
  end
  initial begin
    do_reset();
    rd(8'hE2, 64'h4);
    rd(8'hCE, CAP_EXP);
    wr(8'hCE, '1);
    rd(8'hCE, CAP_EXP);
    wr(8'h10, '1);
    rd(8'h10, 64'h0);
    rd(8'hE4, 64'h0);
    $display("test reset_values done");
    for (int i = 0; i < 6; i++) begin
      wr(8'hE2, 64'(codes[i]));
      cmp(64'({pkgIdleAllowed, pkgDeepestState}),
          64'({i > 1, states[i]}));
      rd(8'hE2, 64'(codes[i]));
    end
    $display("test limit_decode done");
    wr(8'hE4, 64'h1234);
    rd(8'hE4, 64'h1234);
    wr(8'hE2, 64'h0407);
    drive(16'h1234, 4'h1);
    cmp(64'({ioConsumed, idleRequest}), 64'h3);
    drive(16'h1235, 4'h1);
    cmp(64'({ioConsumed, idleRequest}), 64'h0);
    wr(8'hE2, 64'h0007);
    drive(16'h1234, 4'h1);
    cmp(64'({ioConsumed, idleRequest}), 64'h0);
    $display("test io_redirect done");
    coreDeepIdle <= 4'hB;
    drive(16'h0000, 4'h1);
    cmp(64'(coreWake), 64'hB);
    wr(8'hE2, 64'h0100_0007);
    drive(16'h0000, 4'h1);
    cmp(64'(coreWake), 64'h1);
    drive(16'h0000, 4'h4);
    cmp(64'(coreWake), 64'h0);
    $display("test wake_filter done");
    wr(8'hE2, 64'h8407);
    wr(8'hE2, 64'h0100_0000);
    rd(8'hE2, 64'h0100_8407);
    cmp(64'(pkgDeepestState), 64'h7);
    drive(16'h1234, 4'h4);
    cmp(64'({ioConsumed, coreWake}), 64'h10);
    do_reset();
    rd(8'hE2, 64'h4);
    wr(8'hE2, 64'h0);
    rd(8'hE2, 64'h0);
    $display("test lock done");
    test_done();
  end
endmodule

/* File: hw/pscr_defs.svh */
// Offsets, field positions, reset values of the power state register bank
`ifndef PSCR_DEFS_SVH
`define PSCR_DEFS_SVH
`define PSCR_OFF_CAPINFO     8'hCE
`define PSCR_OFF_CSTCFG      8'hE2
`define PSCR_OFF_IOCAP       8'hE4
`define PSCR_BIT_RATIOPROG   28
`define PSCR_BIT_LIMPROG     29
`define PSCR_EFF_LO          40
`define PSCR_EFF_HI          47
`define PSCR_BIT_IOREDIR     10
`define PSCR_BIT_LOCK        15
`define PSCR_BIT_INTFILT     24
`define PSCR_IOCAP_RST       16'h0000
`define PSCR_STEP_KHZ        133330
`endif

/* File: hw/pscr_pkg.sv */
// Types for the power state register bank
package pscr_pkg;
  typedef logic [7:0]  pscr_addr_t;
  typedef logic [63:0] pscr_data_t;
  typedef logic [2:0]  pscr_limit_t;
  typedef enum logic [2:0] {
    PSCR_LIM_NONE_PKG = 3'h0,
    PSCR_LIM_C1       = 3'h1,
    PSCR_LIM_C3       = 3'h2,
    PSCR_LIM_C6       = 3'h3,
    PSCR_LIM_C7       = 3'h4,
    PSCR_LIM_RSV5     = 3'h5,
    PSCR_LIM_RSV6     = 3'h6,
    PSCR_LIM_UNLIM    = 3'h7
  } pscr_limit_e;
endpackage

/* File: hw/pscr_power_state_config_regs.sv */
// Power state configuration and capability register bank
// Notes on behaviour
// - Bit 28 reports programmable boost ratio limits
// - Bit 29 reports programmable current/power limits
// - Bits 47:40 report most efficient ratio
// - Limit field decodes none, C6, C7, unlimited; code 010b acts as C6
// - Code 001b acts like 000b
// - Limit field loads factory value on first clock after reset
// - No limit code restricts package to C3
// - Bit 10 turns reads of the capture base port into idle requests
// - Bit 15 locks bits 15:0 until reset
// - Bit 24 set: wake only addressed core
// - Bit 24 clear: wake on any message
// - Capture base holds redirected port address
`timescale 1ns/1ps
`include "pscr_defs.svh"
module pscr_power_state_config_regs #(
  parameter logic [2:0] FACTORY_LIMIT = 3'h7,
  parameter logic       RATIO_PROG    = 1'b1,
  parameter logic       LIMIT_PROG    = 1'b1,
  parameter logic [7:0] EFF_RATIO     = 8'h07,
  parameter int         CORES         = 4
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire pscr_pkg::pscr_addr_t regAddr,
  input  wire pscr_pkg::pscr_data_t regWdata,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output pscr_pkg::pscr_data_t     regRdata,
  input  wire logic                ioRead,
  input  wire logic [15:0]         ioPort,
  output logic                     ioConsumed,
  output logic                     idleRequest,
  input  wire logic                eventValid,
  input  wire logic [CORES-1:0]    eventTarget,
  input  wire logic [CORES-1:0]    coreDeepIdle,
  output logic [CORES-1:0]         coreWake,
  output logic [2:0]               pkgDeepestState,
  output logic                     pkgIdleAllowed
);
  import pscr_pkg::*;

  logic        limitLoaded_reg, limitLoaded_next;
  logic [2:0]  limit_reg, limit_next;
  logic        ioRedir_reg, ioRedir_next;
  logic        lock_reg, lock_next;
  logic        intFilt_reg, intFilt_next;
  logic [15:0] ioBase_reg, ioBase_next;
  pscr_data_t  rdata_reg, rdata_next;
  pscr_data_t  capWord, cfgWord;
  logic        cfgWr, baseWr;

  always_comb begin
    capWord = '0;
    capWord[`PSCR_BIT_RATIOPROG] = RATIO_PROG;
    capWord[`PSCR_BIT_LIMPROG] = LIMIT_PROG;
    capWord[`PSCR_EFF_HI:`PSCR_EFF_LO] = EFF_RATIO;
    cfgWord = '0;
    cfgWord[2:0] = limit_reg;
    cfgWord[`PSCR_BIT_IOREDIR] = ioRedir_reg;
    cfgWord[`PSCR_BIT_LOCK] = lock_reg;
    cfgWord[`PSCR_BIT_INTFILT] = intFilt_reg;
  end

  assign cfgWr  = regWrite && regAddr == `PSCR_OFF_CSTCFG;
  assign baseWr = regWrite && regAddr == `PSCR_OFF_IOCAP;

  always_comb begin
    limitLoaded_next = 1'b1;
    limit_next   = limitLoaded_reg ? limit_reg : FACTORY_LIMIT;
    ioRedir_next = ioRedir_reg;
    lock_next    = lock_reg;
    intFilt_next = intFilt_reg;
    ioBase_next  = ioBase_reg;
    rdata_next   = '0;
    if (cfgWr) begin
      if (!lock_reg) begin
        limit_next   = regWdata[2:0];
        ioRedir_next = regWdata[`PSCR_BIT_IOREDIR];
        lock_next    = regWdata[`PSCR_BIT_LOCK];
      end
      intFilt_next = regWdata[`PSCR_BIT_INTFILT];
    end
    if (baseWr) begin
      ioBase_next = regWdata[15:0];
    end
    if (regRead) begin
      unique case (regAddr)
        `PSCR_OFF_CAPINFO: rdata_next = capWord;
        `PSCR_OFF_CSTCFG:  rdata_next = cfgWord;
        `PSCR_OFF_IOCAP:   rdata_next = {48'h0, ioBase_reg};
        default:           rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      limitLoaded_reg <= 1'b0;
      limit_reg   <= 3'h0;
      ioRedir_reg <= 1'b0;
      lock_reg    <= 1'b0;
      intFilt_reg <= 1'b0;
      ioBase_reg  <= `PSCR_IOCAP_RST;
      rdata_reg   <= '0;
    end else begin
      limitLoaded_reg <= limitLoaded_next;
      limit_reg   <= limit_next;
      ioRedir_reg <= ioRedir_next;
      lock_reg    <= lock_next;
      intFilt_reg <= intFilt_next;
      ioBase_reg  <= ioBase_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;

  // Redirected port reads become idle requests
  always_comb begin
    ioConsumed  = ioRedir_reg && ioRead && ioPort == ioBase_reg;
    idleRequest = ioConsumed;
  end

  // Deepest allowed package state; C3 code never yields a C3 cap
  always_comb begin
    unique case (limit_reg)
      PSCR_LIM_NONE_PKG, PSCR_LIM_C1: begin
        pkgDeepestState = PSCR_LIM_NONE_PKG;
        pkgIdleAllowed  = 1'b0;
      end
      PSCR_LIM_C3, PSCR_LIM_C6: begin
        pkgDeepestState = PSCR_LIM_C6;
        pkgIdleAllowed  = 1'b1;
      end
      PSCR_LIM_C7: begin
        pkgDeepestState = PSCR_LIM_C7;
        pkgIdleAllowed  = 1'b1;
      end
      default: begin
        pkgDeepestState = PSCR_LIM_UNLIM;
        pkgIdleAllowed  = 1'b1;
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < CORES; g++) begin : gWake
      assign coreWake[g] = eventValid && coreDeepIdle[g] &&
                           (!intFilt_reg || eventTarget[g]);
    end
  endgenerate

  // Lock and write protection
  a_lock_holds: assert property (
    @(posedge clock) disable iff (!rst_n)
    lock_reg |=> lock_reg && $stable(limit_reg) && $stable(ioRedir_reg))
    else $error("locked field changed");
  a_locked_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    (cfgWr && lock_reg) |=> limit_reg == $past(limit_reg))
    else $error("write to locked limit took effect");
  a_lock_redir: assert property (
    @(posedge clock) disable iff (!rst_n)
    (cfgWr && lock_reg) |=> ioRedir_reg == $past(ioRedir_reg))
    else $error("write to locked redirect took effect");
  a_lock_set: assert property (
    @(posedge clock) disable iff (!rst_n)
    (cfgWr && !lock_reg && regWdata[`PSCR_BIT_LOCK]) |=> lock_reg)
    else $error("lock bit not set by write");
  a_unlocked_wr: assert property (
    @(posedge clock) disable iff (!rst_n)
    (cfgWr && !lock_reg) |=> limit_reg == $past(regWdata[2:0]))
    else $error("unlocked limit write lost");
  a_locked_quiet: assert property (
    @(posedge clock) disable iff (!rst_n)
    (cfgWr && lock_reg) |=> $stable(ioBase_reg))
    else $error("locked write disturbed capture base");

  // Port read redirection
  a_redir_req: assert property (
    @(posedge clock) disable iff (!rst_n)
    idleRequest |-> ioRedir_reg && ioRead && ioPort == ioBase_reg)
    else $error("idle request without matching port read");
  a_redir_off: assert property (
    @(posedge clock) disable iff (!rst_n)
    !ioRedir_reg |-> !ioConsumed)
    else $error("port read consumed while redirect off");
  a_redir_hit: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ioRedir_reg && ioRead && ioPort == ioBase_reg) |-> idleRequest)
    else $error("matching port read not redirected");
  a_redir_miss: assert property (
    @(posedge clock) disable iff (!rst_n)
    ioPort != ioBase_reg |-> !ioConsumed)
    else $error("read of other port consumed");

  // Wake filtering
  a_filter_on: assert property (
    @(posedge clock) disable iff (!rst_n)
    intFilt_reg |-> (coreWake & ~eventTarget) == '0)
    else $error("unaddressed core woke while filtering");
  a_wake_addr: assert property (
    @(posedge clock) disable iff (!rst_n)
    (intFilt_reg && eventValid) |-> coreWake == (coreDeepIdle & eventTarget))
    else $error("addressed idle core missed wake");
  a_filt_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    cfgWr |=> intFilt_reg == $past(regWdata[`PSCR_BIT_INTFILT]))
    else $error("filter enable not stored");
  a_filter_off: assert property (
    @(posedge clock) disable iff (!rst_n)
    (!intFilt_reg && eventValid) |-> coreWake == coreDeepIdle)
    else $error("idle core missed broadcast wake");
  a_no_event: assert property (
    @(posedge clock) disable iff (!rst_n)
    !eventValid |-> coreWake == '0)
    else $error("core woke without event");
  a_wake_idle: assert property (
    @(posedge clock) disable iff (!rst_n)
    (coreWake & ~coreDeepIdle) == '0)
    else $error("running core got wake");

  // Limit decode
  a_no_c3_cap: assert property (
    @(posedge clock) disable iff (!rst_n)
    pkgDeepestState != PSCR_LIM_C3)
    else $error("package limited to C3");
  a_c3_maps_c6: assert property (
    @(posedge clock) disable iff (!rst_n)
    limit_reg == PSCR_LIM_C3 |-> pkgDeepestState == PSCR_LIM_C6)
    else $error("code 010b not widened to C6");
  a_c1_like_c0: assert property (
    @(posedge clock) disable iff (!rst_n)
    limit_reg == PSCR_LIM_C1 |-> !pkgIdleAllowed)
    else $error("code 001b allowed package idle");
  a_c1_state: assert property (
    @(posedge clock) disable iff (!rst_n)
    limit_reg == PSCR_LIM_C1 |-> pkgDeepestState == PSCR_LIM_NONE_PKG)
    else $error("code 001b decoded apart from 000b");
  a_decode_none: assert property (
    @(posedge clock) disable iff (!rst_n)
    limit_reg == PSCR_LIM_NONE_PKG |-> !pkgIdleAllowed)
    else $error("code 000b allowed package idle");
  a_decode_c6: assert property (
    @(posedge clock) disable iff (!rst_n)
    limit_reg == PSCR_LIM_C6 |-> pkgDeepestState == PSCR_LIM_C6)
    else $error("code 011b not decoded as C6");
  a_decode_c7: assert property (
    @(posedge clock) disable iff (!rst_n)
    limit_reg == PSCR_LIM_C7 |-> pkgDeepestState == PSCR_LIM_C7)
    else $error("code 100b not decoded as C7");
  a_decode_unlim: assert property (
    @(posedge clock) disable iff (!rst_n)
    limit_reg == PSCR_LIM_UNLIM |-> pkgDeepestState == PSCR_LIM_UNLIM)
    else $error("code 111b not decoded as unlimited");
  a_factory_rst: assert property (
    @(posedge clock) disable iff (!rst_n)
    (!limitLoaded_reg && !lock_reg) |=> limit_reg == FACTORY_LIMIT ||
      $past(cfgWr))
    else $error("limit not loaded with factory value");

  // Register reads
  a_cap_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    (regRead && regAddr == `PSCR_OFF_CAPINFO) |=>
      regRdata[`PSCR_BIT_RATIOPROG] == RATIO_PROG)
    else $error("capability ratio bit wrong");
  a_cap_limprog: assert property (
    @(posedge clock) disable iff (!rst_n)
    (regRead && regAddr == `PSCR_OFF_CAPINFO) |=>
      regRdata[`PSCR_BIT_LIMPROG] == LIMIT_PROG)
    else $error("capability limit bit wrong");
  a_cap_eff: assert property (
    @(posedge clock) disable iff (!rst_n)
    (regRead && regAddr == `PSCR_OFF_CAPINFO) |=>
      regRdata[`PSCR_EFF_HI:`PSCR_EFF_LO] == EFF_RATIO)
    else $error("capability efficiency ratio wrong");
  a_cap_rsvd: assert property (
    @(posedge clock) disable iff (!rst_n)
    (regRead && regAddr == `PSCR_OFF_CAPINFO) |=>
      regRdata[63:48] == '0 && regRdata[39:30] == '0 &&
      regRdata[27:0] == '0)
    else $error("capability reserved bits set");
  a_cfg_rsvd: assert property (
    @(posedge clock) disable iff (!rst_n)
    (regRead && regAddr == `PSCR_OFF_CSTCFG) |=>
      regRdata[9:3] == '0 && regRdata[14:11] == '0 &&
      regRdata[23:16] == '0 && regRdata[63:25] == '0)
    else $error("config reserved bits set");
  a_rdata_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    !regRead |=> regRdata == '0)
    else $error("read data without read");

  // Capture base
  a_base_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    baseWr |=> ioBase_reg == $past(regWdata[15:0]))
    else $error("capture base not stored");
  a_base_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !baseWr |=> $stable(ioBase_reg))
    else $error("capture base changed without write");
  a_base_read: assert property (
    @(posedge clock) disable iff (!rst_n)
    (regRead && regAddr == `PSCR_OFF_IOCAP) |=>
      regRdata == {48'h0, $past(ioBase_reg)})
    else $error("capture base read wrong");
endmodule
